//--- hdl/sfp_port.sv
// sfp_port: serial audio data port, core side registers and bit clock side framing
// Behaviour
// - two-channel, four-slot and eight-slot tdm, both ways
// - two's complement words, always msb first
// - left channel precedes right channel
// - tdm4 slots 0-1 first half, 2-3 second
// - tdm8 slots 0-3 first half, 4-7 second
// - one clock pair, both directions master together
// - 64, 128 or 256 bit clocks per frame
// - tdm frame clock square or one-bit pulse
// - tdm output always driven, zero in empty slots
// - master tdm8 refused at 96 kHz
// - bclk, lrclk polarity and format selectable
// - i2s falling edge start, one bit lag
// - left-justified rising start, no lag
// - right-justified rising start, 8/12/16 bit lag
// - rj set by bits-per-frame and delay fields
// - tdm 64-256 bits, one bit lag, edge by mode
module sfp_port import sfp_pkg::*; #(
	parameter int WORD_W = 24,
	parameter int SLOTS = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic bclk,
	output logic bclk_out,
	output logic bclk_oe_n,
	input wire logic lrclk_in,
	output logic lrclk_out,
	output logic lrclk_oe_n,
	input wire logic sdata_in,
	output logic sdata_out,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic tx_wr,
	input wire logic [$clog2(SLOTS)-1:0] tx_slot,
	input wire logic [WORD_W-1:0] tx_data,
	output logic rx_valid,
	output logic [$clog2(SLOTS)-1:0] rx_slot,
	output logic [WORD_W-1:0] rx_data,
	output logic cfg_err
);
	localparam int SW = $clog2(SLOTS);

	// refuse shapes the framing cannot serve
	if (WORD_W < 8 || WORD_W > SFP_WORD_MAX || SLOTS != SFP_SLOT_MAX) begin : g_bad
		$error("sfp_port: WORD_W must be 8..24 and SLOTS must be 8");
	end

	// --------------------------------------------------------------
	// core domain: control registers
	// --------------------------------------------------------------
	logic [7:0] fmt_a_q; // serial_format_ctrl_a
	logic [7:0] fmt_b_q; // serial_format_ctrl_b
	logic [7:0] conv_a_q; // converter_ctrl_a
	logic [7:0] conv_b_q; // converter_ctrl_b
	logic err_d; // master request that cannot be served
	logic master_d; // master role actually taken

	// software writes, one byte per register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fmt_a_q <= SFP_RST_FMT_A;
			fmt_b_q <= SFP_RST_FMT_B;
			conv_a_q <= SFP_RST_CONV_A;
			conv_b_q <= SFP_RST_CONV_B;
		end else if (reg_wr) begin
			case (reg_addr)
				SFP_ADDR_FMT_A: fmt_a_q <= reg_wdata;
				SFP_ADDR_FMT_B: fmt_b_q <= reg_wdata;
				SFP_ADDR_CONV_A: conv_a_q <= reg_wdata;
				SFP_ADDR_CONV_B: conv_b_q <= reg_wdata;
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	// eight-slot master at 96 kHz would need a bclk the divider cannot make
	assign err_d = fmt_a_q[SFP_FA_MASTER] && fmt_a_q[SFP_FA_TDM8] && conv_a_q[SFP_CA_FS96]
		&& (fmt_a_q[SFP_FA_FMT_LSB+:2] == SFP_FMT_TDM);
	assign master_d = fmt_a_q[SFP_FA_MASTER] && !err_d && conv_a_q[SFP_CA_EN];

	// registered read data, unmapped addresses read zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				SFP_ADDR_FMT_A: reg_rdata <= fmt_a_q;
				SFP_ADDR_FMT_B: reg_rdata <= fmt_b_q;
				SFP_ADDR_CONV_A: reg_rdata <= {cfg_err, conv_a_q[SFP_CA_ERR-1:0]};
				SFP_ADDR_CONV_B: reg_rdata <= conv_b_q;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// --------------------------------------------------------------
	// core domain: master clock divider
	// --------------------------------------------------------------
	logic [7:0] div_cnt_q; // core clocks into the current bclk half
	logic [7:0] div_top; // last count of a half, zero treated as one

	assign div_top = (conv_b_q == 8'h00) ? 8'h00 : conv_b_q - 8'h01;

	// bclk is the core clock divided by twice conv_b; idles at its polarity
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_q <= 8'h00;
			bclk_out <= 1'b0;
		end else if (!master_d) begin
			div_cnt_q <= 8'h00;
			bclk_out <= fmt_a_q[SFP_FA_BCLK_POL];
		end else if (div_cnt_q >= div_top) begin
			div_cnt_q <= 8'h00;
			bclk_out <= !bclk_out;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	// one role for both clock pins and both directions
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_oe_n <= 1'b1;
			lrclk_oe_n <= 1'b1;
			cfg_err <= 1'b0;
		end else begin
			bclk_oe_n <= !master_d;
			lrclk_oe_n <= !master_d;
			cfg_err <= err_d;
		end
	end

	// --------------------------------------------------------------
	// core domain: transmit slot memory and frame snapshot
	// --------------------------------------------------------------
	logic [WORD_W-1:0] mem_rd; // memory read data
	logic [SW-1:0] fill_idx_q; // slot being read
	logic [SW-1:0] fill_lat_q; // slot whose data arrives now
	logic fill_vld_q; // read data valid this cycle
	logic fill_ack_q; // toggles when the snapshot is complete
	logic fill_req_s; // synchronised request from the link
	sfp_fill_t fill_q; // fill sequence state
	logic [WORD_W-1:0] hold_q [SLOTS]; // snapshot read by the link while req equals ack

	sfp_slot_mem #(.W(WORD_W), .D(SLOTS)) u_mem (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(tx_wr),
		.wr_addr(tx_slot),
		.wr_data(tx_data),
		.rd_addr(fill_idx_q),
		.rd_data(mem_rd)
	);

	// walk all slots once per request, then answer by toggling ack
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fill_q <= SFP_FILL_IDLE;
			fill_idx_q <= '0;
			fill_ack_q <= 1'b0;
		end else begin
			case (fill_q)
				SFP_FILL_IDLE: begin
					fill_idx_q <= '0;
					if (fill_req_s != fill_ack_q) begin
						fill_q <= SFP_FILL_READ;
					end
				end
				SFP_FILL_READ: begin
					fill_idx_q <= fill_idx_q + 1'b1;
					if (fill_idx_q == SW'(SLOTS - 1)) begin
						fill_q <= SFP_FILL_DONE;
					end
				end
				SFP_FILL_DONE: begin
					fill_ack_q <= !fill_ack_q;
					fill_q <= SFP_FILL_IDLE;
				end
				default: fill_q <= SFP_FILL_IDLE;
			endcase
		end
	end

	// memory latency tracking and snapshot load
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fill_vld_q <= 1'b0;
			fill_lat_q <= '0;
			for (int i = 0; i < SLOTS; i++) begin
				hold_q[i] <= '0;
			end
		end else begin
			fill_vld_q <= (fill_q == SFP_FILL_READ);
			fill_lat_q <= fill_idx_q;
			if (fill_vld_q) begin
				hold_q[fill_lat_q] <= mem_rd;
			end
		end
	end

	// --------------------------------------------------------------
	// crossings between the two domains
	// --------------------------------------------------------------
	localparam int CW = 12; // width of the configuration bundle
	logic [CW-1:0] cfg_c; // configuration, core side
	logic [CW-1:0] cfg_l; // configuration, link side
	logic rx_tgl_q; // link: toggles per finished slot
	logic rx_tgl_s; // core: synchronised slot toggle
	logic rx_seen_q; // core: last toggle taken
	logic fill_req_q; // link: snapshot request toggle
	logic fill_ack_s; // link: synchronised ack
	logic lr_s; // link: synchronised frame clock pin
	logic sd_s; // link: synchronised data pin

	// quasi-static: change only while the port is disabled
	assign cfg_c = {conv_a_q[SFP_CA_EN], master_d, fmt_a_q[SFP_FA_LR_POL],
		fmt_a_q[SFP_FA_PULSE], fmt_a_q[SFP_FA_TDM8], fmt_a_q[SFP_FA_FMT_LSB+:2],
		fmt_b_q[SFP_FB_BPF_LSB+:3], fmt_b_q[SFP_FB_DLY_LSB+:2]};

	sfp_sync2 #(.W(CW)) u_cfg (.clk(bclk), .reset_n(reset_n), .d(cfg_c), .q(cfg_l));
	sfp_sync2 #(.W(2)) u_pin (.clk(bclk), .reset_n(reset_n), .d({lrclk_in, sdata_in}),
		.q({lr_s, sd_s}));
	sfp_sync2 #(.W(1)) u_ack (.clk(bclk), .reset_n(reset_n), .d(fill_ack_q), .q(fill_ack_s));
	sfp_sync2 #(.W(1)) u_req (.clk(clk), .reset_n(reset_n), .d(fill_req_q), .q(fill_req_s));
	sfp_sync2 #(.W(1)) u_rxt (.clk(clk), .reset_n(reset_n), .d(rx_tgl_q), .q(rx_tgl_s));

	// --------------------------------------------------------------
	// link domain: frame decode
	// --------------------------------------------------------------
	logic en_l, mst_l, lrpol_l, pulse_l, tdm8_l; // unpacked configuration
	logic [1:0] fmt_l, dsel_l;
	logic [2:0] bsel_l;
	logic lr_prev_q; // frame clock one bit earlier
	logic lr_v, lr_pv, rise, fall, start; // frame edge detection
	logic [3:0] bpf_lg, slot_lg, sw_lg; // log2 of frame, slot count, slot width
	logic [7:0] fmask, swmask, dly, pos, eff, teff, bit_i, tbit;
	logic [SW-1:0] slot_i, tslot;
	logic [7:0] cnt_q; // bit position counter in the frame
	logic [WORD_W-1:0] acc_q, acc_d; // receive word under assembly
	logic emit; // last bit of a slot
	logic [WORD_W-1:0] rx_word_q; // finished word, stable for a slot
	logic [SW-1:0] rx_slot_q;
	logic [WORD_W-1:0] shadow_q [SLOTS]; // words sent during the current frame
	logic tx_bit_q; // next serial output bit
	logic [7:0] mgen_q; // master frame clock counter
	logic lr_gen_q; // master frame clock level

	assign {en_l, mst_l, lrpol_l, pulse_l, tdm8_l, fmt_l, bsel_l, dsel_l} = cfg_l;

	assign lr_v = lr_s ^ lrpol_l;
	assign lr_pv = lr_prev_q ^ lrpol_l;
	assign rise = lr_v && !lr_pv;
	assign fall = !lr_v && lr_pv;
	// i2s and square tdm start on the fall, the rest on the rise
	assign start = (fmt_l == SFP_FMT_I2S || (fmt_l == SFP_FMT_TDM && !pulse_l)) ? fall
		: rise;

	// frame and slot geometry from the setting
	always_comb begin
		case (bsel_l)
			3'h1: bpf_lg = 4'h7;
			3'h2: bpf_lg = 4'h8;
			default: bpf_lg = 4'h6;
		endcase
		if (fmt_l != SFP_FMT_TDM) begin
			slot_lg = 4'h1;
		end else begin
			slot_lg = tdm8_l ? 4'h3 : 4'h2;
		end
		sw_lg = bpf_lg - slot_lg;
		fmask = 8'hff >> (4'h8 - bpf_lg);
		swmask = 8'hff >> (4'h8 - sw_lg);
	end

	// data lag behind the frame edge
	always_comb begin
		case (fmt_l)
			SFP_FMT_LJ: dly = 8'h00;
			SFP_FMT_RJ: begin
				case (dsel_l)
					2'h0: dly = SFP_DLY_RJ0;
					2'h1: dly = SFP_DLY_RJ1;
					default: dly = SFP_DLY_RJ2;
				endcase
			end
			default: dly = SFP_DLY_STD;
		endcase
	end

	// a whole-frame shift keeps slots in order: low slots in the first half
	assign pos = start ? 8'h00 : cnt_q;
	assign eff = (pos - dly) & fmask;
	assign bit_i = eff & swmask;
	assign slot_i = SW'(eff >> sw_lg);
	assign teff = (pos + SFP_TX_LEAD + 8'h01 - dly) & fmask; // plus the output register
	assign tbit = teff & swmask;
	assign tslot = SW'(teff >> sw_lg);
	assign emit = en_l && (bit_i == swmask);

	// msb lands first; bits past the word are dropped, shorter words zero-fill
	always_comb begin
		acc_d = (bit_i == 8'h00) ? '0 : acc_q;
		if (int'(bit_i) < WORD_W) begin
			acc_d[WORD_W - 1 - int'(bit_i)] = sd_s;
		end
	end

	// counter restarts at every frame start edge, not at the opposite edge
	always_ff @(posedge bclk or negedge reset_n) begin
		if (!reset_n) begin
			lr_prev_q <= 1'b0;
			cnt_q <= 8'h00;
			acc_q <= '0;
		end else begin
			lr_prev_q <= lr_s;
			cnt_q <= (pos + 8'h01) & fmask;
			acc_q <= en_l ? acc_d : '0;
		end
	end

	// --------------------------------------------------------------
	// link domain: receive hand-off
	// --------------------------------------------------------------
	always_ff @(posedge bclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_word_q <= '0;
			rx_slot_q <= '0;
			rx_tgl_q <= 1'b0;
		end else if (emit) begin
			rx_word_q <= acc_d;
			rx_slot_q <= slot_i;
			rx_tgl_q <= !rx_tgl_q;
		end
	end

	// core takes the word once the toggle has crossed; it stays put for a slot
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_seen_q <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= '0;
			rx_slot <= '0;
		end else begin
			rx_seen_q <= rx_tgl_s;
			rx_valid <= (rx_tgl_s != rx_seen_q);
			if (rx_tgl_s != rx_seen_q) begin
				rx_data <= rx_word_q;
				rx_slot <= rx_slot_q;
			end
		end
	end

	// --------------------------------------------------------------
	// link domain: transmit
	// --------------------------------------------------------------
	// swap snapshots one bit before slot 0 is prepared, so no word mixes two frames
	always_ff @(posedge bclk or negedge reset_n) begin
		if (!reset_n) begin
			fill_req_q <= 1'b0;
			for (int i = 0; i < SLOTS; i++) begin
				shadow_q[i] <= '0;
			end
		end else if (teff == fmask && fill_ack_s == fill_req_q) begin
			shadow_q <= hold_q;
			fill_req_q <= !fill_req_q;
		end
	end

	// empty bit positions still drive zero, never released
	always_ff @(posedge bclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_bit_q <= 1'b0;
		end else if (en_l && int'(tbit) < WORD_W) begin
			tx_bit_q <= shadow_q[tslot][WORD_W - 1 - int'(tbit)];
		end else begin
			tx_bit_q <= 1'b0;
		end
	end

	// master frame clock: square wave or one-bit pulse per frame
	always_ff @(posedge bclk or negedge reset_n) begin
		if (!reset_n) begin
			mgen_q <= 8'h00;
			lr_gen_q <= 1'b0;
		end else if (!mst_l) begin
			mgen_q <= 8'h00;
			lr_gen_q <= lrpol_l;
		end else begin
			mgen_q <= (mgen_q + 8'h01) & fmask;
			if (fmt_l == SFP_FMT_TDM && pulse_l) begin
				lr_gen_q <= (mgen_q == 8'h00) ^ lrpol_l;
			end else if (fmt_l == SFP_FMT_I2S || fmt_l == SFP_FMT_TDM) begin
				lr_gen_q <= (mgen_q >= (fmask >> 1) + 8'h01) ^ lrpol_l;
			end else begin
				lr_gen_q <= (mgen_q < (fmask >> 1) + 8'h01) ^ lrpol_l;
			end
		end
	end

	// pins change on the falling bit clock edge
	always_ff @(negedge bclk or negedge reset_n) begin
		if (!reset_n) begin
			sdata_out <= 1'b0;
			lrclk_out <= 1'b0;
		end else begin
			sdata_out <= tx_bit_q;
			lrclk_out <= lr_gen_q;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	chk_master_refused: assert property (@(posedge clk) disable iff (!reset_n)
		err_d |=> cfg_err && bclk_oe_n)
		else $error("master tdm8 at 96 kHz was not refused");
	chk_shared_role: assert property (@(posedge clk) disable iff (!reset_n)
		bclk_oe_n == lrclk_oe_n)
		else $error("clock pins disagree on role");
	chk_i2s_lag: assert property (@(posedge bclk) disable iff (!reset_n)
		(start && fmt_l == SFP_FMT_I2S) |-> eff == fmask)
		else $error("i2s data not one bit behind frame edge");
	chk_lj_align: assert property (@(posedge bclk) disable iff (!reset_n)
		(start && fmt_l == SFP_FMT_LJ) |-> eff == 8'h00)
		else $error("left-justified data not on frame edge");
	chk_rj_delay: assert property (@(posedge bclk) disable iff (!reset_n)
		(start && fmt_l == SFP_FMT_RJ && dsel_l == 2'h1) |-> eff == ((8'h00 - 8'h0c) & fmask))
		else $error("right-justified delay wrong");
	chk_frame_restart: assert property (@(posedge bclk) disable iff (!reset_n)
		start |=> cnt_q == 8'h01)
		else $error("counter did not restart at frame edge");
	chk_msb_first: assert property (@(posedge bclk) disable iff (!reset_n)
		(en_l && bit_i == 8'h00) |=> acc_q[WORD_W-1] == $past(sd_s))
		else $error("first bit not stored as msb");
	chk_truncate: assert property (@(posedge bclk) disable iff (!reset_n)
		(en_l && int'(bit_i) >= WORD_W) |=> $stable(acc_q))
		else $error("bit beyond word width was stored");
	chk_slot_half: assert property (@(posedge bclk) disable iff (!reset_n)
		emit |-> ((eff <= (fmask >> 1)) == (int'(slot_i) < (1 << (slot_lg - 4'h1)))))
		else $error("slot in wrong half of frame");
	chk_idle_zero: assert property (@(posedge bclk) disable iff (!reset_n)
		(en_l && int'(tbit) >= WORD_W) |=> !tx_bit_q)
		else $error("empty slot bit not driven low");
	chk_pulse_start: assert property (@(posedge bclk) disable iff (!reset_n)
		(fmt_l == SFP_FMT_TDM && pulse_l && rise) |-> start)
		else $error("pulse frame clock rise missed");
	chk_rx_handoff: assert property (@(posedge bclk) disable iff (!reset_n)
		emit |=> rx_tgl_q != $past(rx_tgl_q) && rx_slot_q == $past(slot_i))
		else $error("finished slot not handed over");
endmodule : sfp_port

//--- hdl/sfp_slot_mem.sv
// sfp_slot_mem: small word memory for transmit slots, registered read data
module sfp_slot_mem #(
	parameter int W = 24,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [$clog2(D)-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	input wire logic [$clog2(D)-1:0] rd_addr,
	output logic [W-1:0] rd_data
);
	logic [W-1:0] mem [D]; // storage, not reset: contents are don't-care until written

	// --------------------------------------------------------------
	// write port
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// --------------------------------------------------------------
	// read port, one cycle latency
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : sfp_slot_mem

//--- hdl/sfp_sync2.sv
// sfp_sync2: two flip-flop level synchroniser, one per bit
module sfp_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// first stage is read by the second stage only
	logic [W-1:0] meta_q;

	// --------------------------------------------------------------
	// both stages
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : sfp_sync2

//--- pkg/sfp_pkg.sv
// sfp_pkg: register map, field layout and constants of the serial audio data port
package sfp_pkg;

	// --------------------------------------------------------------
	// register offsets on the control port
	// --------------------------------------------------------------
	localparam logic [15:0] SFP_ADDR_FMT_A = 16'h4015; // serial_format_ctrl_a
	localparam logic [15:0] SFP_ADDR_FMT_B = 16'h4016; // serial_format_ctrl_b
	localparam logic [15:0] SFP_ADDR_CONV_A = 16'h4017; // converter_ctrl_a
	localparam logic [15:0] SFP_ADDR_CONV_B = 16'h4018; // converter_ctrl_b

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [7:0] SFP_RST_FMT_A = 8'h00;
	localparam logic [7:0] SFP_RST_FMT_B = 8'h00;
	localparam logic [7:0] SFP_RST_CONV_A = 8'h00;
	localparam logic [7:0] SFP_RST_CONV_B = 8'h04; // bclk half period in core clocks

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int SFP_FA_MASTER = 0; // 1: port drives bclk and lrclk
	localparam int SFP_FA_BCLK_POL = 1; // idle level of the driven bclk
	localparam int SFP_FA_LR_POL = 2; // inverts the frame clock
	localparam int SFP_FA_FMT_LSB = 3; // two bits, format code
	localparam int SFP_FA_TDM8 = 5; // tdm: 0 four slots, 1 eight slots
	localparam int SFP_FA_PULSE = 6; // tdm: frame clock is a one-bit pulse
	localparam int SFP_FB_BPF_LSB = 5; // three bits, bit clocks per frame
	localparam int SFP_FB_DLY_LSB = 0; // two bits, right-justified delay
	localparam int SFP_CA_FS96 = 0; // sample rate is 96 kHz
	localparam int SFP_CA_EN = 1; // port enable
	localparam int SFP_CA_ERR = 7; // read only: master setting refused

	// --------------------------------------------------------------
	// format codes and link constants
	// --------------------------------------------------------------
	localparam logic [1:0] SFP_FMT_I2S = 2'h0;
	localparam logic [1:0] SFP_FMT_LJ = 2'h1;
	localparam logic [1:0] SFP_FMT_RJ = 2'h2;
	localparam logic [1:0] SFP_FMT_TDM = 2'h3;
	localparam logic [7:0] SFP_DLY_STD = 8'h01; // i2s and tdm data lag
	localparam logic [7:0] SFP_DLY_RJ0 = 8'h08;
	localparam logic [7:0] SFP_DLY_RJ1 = 8'h0c;
	localparam logic [7:0] SFP_DLY_RJ2 = 8'h10;
	localparam int SFP_WORD_MAX = 24; // widest sample word kept
	localparam int SFP_SLOT_MAX = 8; // widest tdm frame
	localparam logic [7:0] SFP_TX_LEAD = 8'h02; // pin synchroniser depth

	// tx slot memory fill sequence
	typedef enum logic [1:0] {SFP_FILL_IDLE, SFP_FILL_READ, SFP_FILL_DONE} sfp_fill_t;

endpackage : sfp_pkg

//--- sim/sfp_far_end.sv
// sfp_far_end: external converter model that clocks the port as slave
module sfp_far_end (
	output logic bclk,
	output logic lrclk,
	output logic sdata,
	input wire logic sdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] cap [2]; // words heard from the port, left then right
	// idle lines; two bit clocks let the link side see reset
	initial begin
		bclk = 1'b0;
		lrclk = 1'b0;
		sdata = 1'b0;
		repeat (4) #15 bclk = ~bclk;
	end
	// --------------------------------------------------------------
	// one frame of 64 bit clocks; bclk stands still outside frames
	// --------------------------------------------------------------
	task automatic frame(input logic [23:0] l, input logic [23:0] r, input int lag,
		input logic lhi);
		int h;
		int k;
		logic [23:0] w;
		for (int p = 0; p < 64; p++) begin
			h = ((p - lag + 64) % 64) / 32; // slot that owns this bit
			k = (p - lag + 64) % 32; // bit within the slot
			w = (h == 0) ? l : r;
			lrclk = (p < 32) ? lhi : ~lhi; // left half level by format
			sdata = (k < 24) ? w[23 - k] : p[0]; // msb first, filler toggles
			#15 bclk = 1'b1; // fixed 30 ns period
			if (k < 24) begin
				cap[h][23 - k] = sdata_out; // sampled on the rising edge
			end
			#15 bclk = 1'b0;
		end
		sdata = ~sdata; // released line shows no stale value
	endtask : frame
endmodule : sfp_far_end

//--- sim/sfp_port_bench.sv
// sfp_port_bench: self-checking bench of the serial audio data port
module sfp_port_bench import sfp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic reg_wr = 1'b0;
	logic tx_wr = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic [2:0] tx_slot = 3'h0;
	logic [23:0] tx_data = 24'h000000;
	logic bclk, lrclk, sdata, bclk_out, bclk_oe_n, lrclk_out, lrclk_oe_n;
	logic sdata_out, rx_valid, cfg_err;
	logic [2:0] rx_slot;
	logic [23:0] rx_data;
	logic [7:0] reg_rdata;
	logic [23:0] got [8]; // last word seen per slot
	int mismatches = 0;
	int checked = 0;
	// as master the port's own clocks come back through the pins
	sfp_port DUT (.clk, .reset_n, .bclk(bclk_oe_n ? bclk : bclk_out), .bclk_out, .bclk_oe_n,
		.lrclk_in(lrclk_oe_n ? lrclk : lrclk_out),
		.lrclk_out, .lrclk_oe_n, .sdata_in(sdata), .sdata_out, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rdata, .tx_wr, .tx_slot, .tx_data, .rx_valid, .rx_slot,
		.rx_data, .cfg_err);
	sfp_far_end far (.bclk, .lrclk, .sdata, .sdata_out);
	// 50 ns core clock
	always #25 clk = ~clk;
	// collect received words by slot
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			got[rx_slot] <= rx_data;
		end
	end
	// --------------------------------------------------------------
	// shared helpers
	// --------------------------------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk) #1;
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk) #1;
		reg_addr = a;
		@(posedge clk) #1;
		check({16'h0000, reg_rdata}, {16'h0000, exp});
	endtask : rd
	task automatic tx(input logic [2:0] s, input logic [23:0] d);
		@(posedge clk) #1;
		tx_slot = s;
		tx_data = d;
		tx_wr = 1'b1;
		@(posedge clk) #1;
		tx_wr = 1'b0;
	endtask : tx
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_regs;
		rd(SFP_ADDR_FMT_A, SFP_RST_FMT_A);
		rd(SFP_ADDR_FMT_B, SFP_RST_FMT_B);
		rd(SFP_ADDR_CONV_A, SFP_RST_CONV_A);
		rd(SFP_ADDR_CONV_B, SFP_RST_CONV_B);
		wr(SFP_ADDR_FMT_B, 8'ha5);
		wr(16'h4019, 8'hff); // unmapped write must not land anywhere
		rd(SFP_ADDR_FMT_B, 8'ha5);
		rd(16'h4019, 8'h00);
		wr(SFP_ADDR_FMT_B, 8'h00);
		$display("register test done");
	endtask : t_regs
	task automatic t_stream(input logic [7:0] fmt, input int lag, input logic lhi);
		logic [23:0] l;
		logic [23:0] r;
		l = 24'h9a5c31 ^ {16'h0000, fmt}; // negative word, differs per run
		r = 24'h3c0ff1 ^ {fmt, 16'h0000}; // differs per run, stale words cannot pass
		wr(SFP_ADDR_FMT_A, fmt);
		wr(SFP_ADDR_CONV_A, 8'h02);
		tx(3'h0, ~l);
		tx(3'h1, ~r);
		repeat (3) far.frame(l, r, lag, lhi);
		repeat (10) @(posedge clk);
		check(got[0], l);
		check(got[1], r);
		check(far.cap[0], ~l);
		check(far.cap[1], ~r);
		check({23'h000000, bclk_oe_n & lrclk_oe_n}, 24'h000001);
		wr(SFP_ADDR_CONV_A, 8'h00);
		$display("stream test %h done", fmt);
	endtask : t_stream
	task automatic t_master;
		logic b; // clock level seen half a period earlier
		wr(SFP_ADDR_FMT_A, 8'h39); // master, tdm, eight slots
		wr(SFP_ADDR_CONV_A, 8'h03); // 96 kHz and enabled
		repeat (8) @(posedge clk);
		check({22'h000000, cfg_err, bclk_oe_n}, 24'h000003);
		rd(SFP_ADDR_CONV_A, 8'h83);
		wr(SFP_ADDR_CONV_A, 8'h02); // 48 kHz is allowed
		repeat (8) @(posedge clk);
		check({21'h000000, cfg_err, bclk_oe_n, lrclk_oe_n}, 24'h000000);
		repeat (64) @(posedge clk);
		#1 b = lrclk_out;
		repeat (256) @(posedge clk); // half of a 64 bit frame at 8 core clocks per bit
		#1 check({23'h000000, lrclk_out}, {23'h000000, ~b});
		b = bclk_out;
		repeat (4) @(posedge clk); // reset conv_b: four core clocks per bclk half
		#1 check({23'h000000, bclk_out}, {23'h000000, ~b});
		wr(SFP_ADDR_CONV_A, 8'h00);
		$display("master test done");
	endtask : t_master
	task automatic stop_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	// watchdog cuts a hang short
	initial begin
		#2000000;
		mismatches++;
		stop_test();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		t_regs();
		t_stream(8'h08, 0, 1'b1);
		t_stream(8'h00, 1, 1'b0);
		wr(SFP_ADDR_FMT_B, 8'h01); // right-justified with a 12 bit clock delay
		t_stream(8'h10, 12, 1'b1);
		t_master();
		stop_test();
	end
endmodule : sfp_port_bench
